// ### adcct_addr_match.sv
// serial bus address phase: start/stop detect, address compare, acknowledge
`timescale 1ns/10ps
`default_nettype none
module adcct_addr_match (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       clk_en,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [6:0] my_addr,
   output logic            sda_oe,
   output logic            matched
);
   typedef struct packed {
      adcct_pkg::adcct_ist_t ph;
      logic                  scl_d;
      logic                  sda_d;
      logic [3:0]            cnt;
      logic [7:0]            sh;
      logic                  ack;
      logic                  hit;
   } adcct_am_t;

   adcct_am_t st;
   adcct_am_t next_st;

   always_comb begin
      next_st = st;
      next_st.hit = 1'b0;
      if (clk_en) begin
         next_st.scl_d = scl;
         next_st.sda_d = sda;
         if (scl && st.scl_d && adcct_pkg::fall(st.sda_d, sda)) begin
            next_st.ph  = adcct_pkg::ADCCT_ADDR;
            next_st.cnt = 4'h0;
            next_st.ack = 1'b0;
         end else if (scl && st.scl_d && adcct_pkg::rise(st.sda_d, sda)) begin
            next_st.ph  = adcct_pkg::ADCCT_IDLE;
            next_st.ack = 1'b0;
         end else begin
            case (st.ph)
               adcct_pkg::ADCCT_ADDR: begin
                  if (adcct_pkg::rise(st.scl_d, scl)) begin
                     next_st.sh  = {st.sh[6:0], sda};
                     next_st.cnt = st.cnt + 4'h1;
                  end else if (adcct_pkg::fall(st.scl_d, scl) && st.cnt == 4'h8) begin
                     if (st.sh[7:1] == my_addr) begin
                        next_st.ph  = adcct_pkg::ADCCT_ACK;
                        next_st.ack = 1'b1;
                        next_st.hit = 1'b1;
                     end else begin
                        next_st.ph = adcct_pkg::ADCCT_REST;
                     end
                  end
               end
               adcct_pkg::ADCCT_ACK: begin
                  if (adcct_pkg::fall(st.scl_d, scl)) begin
                     next_st.ph  = adcct_pkg::ADCCT_REST;
                     next_st.ack = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sda_oe  = st.ack;
   assign matched = st.hit;
endmodule
`default_nettype wire

// ### adcct_i2c_host.sv
// serial bus host model for the address phase
`timescale 1ns/10ps
`default_nettype none
module adcct_i2c_host (
   input  wire logic core_clk,
   input  wire logic sda_oe,
   output logic      scl,
   output wire logic sda
);
   logic drv_low;
   assign sda = ~(drv_low | sda_oe);
   initial begin
      scl = 1'b1;
      drv_low = 1'b0;
   end
   task automatic addr_phase(input logic [7:0] b, output logic ack);
      @(posedge core_clk);
      #13 drv_low = 1'b1;
      #200 scl = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #100 drv_low = ~b[i];
         #100 scl = 1'b1;
         #200 scl = 1'b0;
      end
      #100 drv_low = 1'b0;
      #100 scl = 1'b1;
      #100 ack = sda;
      #100 scl = 1'b0;
      #100 drv_low = 1'b1;
      #100 scl = 1'b1;
      #200 drv_low = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### adcct_pkg.sv
// shared constants, types and helpers of the converter control block
package adcct_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS     = 50;
   localparam int PWRUP_NS   = 1000;
   localparam int CONV_NS    = 2000;
   localparam int PWRUP_CYC  = (PWRUP_NS / CLK_NS < 1) ? 1 : PWRUP_NS / CLK_NS;
   localparam int CONV_CYC   = (CONV_NS / CLK_NS < 1) ? 1 : CONV_NS / CLK_NS;
   localparam int CNT_W      = 6;
   localparam int SYNC_CYC   = 2;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] CFG_OFS    = 8'h00;
   localparam logic [7:0] UPPER_OFS  = 8'h04;
   localparam logic [7:0] LOWER_OFS  = 8'h08;
   localparam logic [7:0] RESULT_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam int CFG_CHSEL_POS  = 0;
   localparam int CFG_ALEN_POS   = 4;
   localparam int CFG_BUSY_POS   = 5;
   localparam int CFG_MODE_POS   = 6;
   localparam int RES_CH_POS     = 12;
   localparam int RES_BAD_POS    = 15;
   localparam int ST_ALERT_POS   = 0;
   localparam int ST_BUSY_POS    = 1;
   localparam int ST_STATE_POS   = 2;
   localparam int ST_ADDR_POS    = 4;
   localparam logic [6:0]  CFG_RST    = 7'h00;
   localparam logic [11:0] UPPER_RST  = 12'hFFF;
   localparam logic [11:0] LOWER_RST  = 12'h000;

   // ****************************************
   // slave addresses
   // ****************************************
   localparam logic [6:0] ADDR_FLOAT = 7'h20;
   localparam logic [6:0] ADDR_V0_GND = 7'h21;
   localparam logic [6:0] ADDR_V0_VDD = 7'h22;
   localparam logic [6:0] ADDR_V1_GND = 7'h23;
   localparam logic [6:0] ADDR_V1_VDD = 7'h24;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic up_read;
      logic down_read;
   } adcct_as_t;

   typedef struct packed {
      logic ref_from_pin;
      logic second_channel;
      logic powered;
      logic hold;
   } adcct_ana_t;

   typedef enum logic [1:0] {
      ADCCT_SLEEP = 2'b00,
      ADCCT_PWRUP = 2'b01,
      ADCCT_READY = 2'b11,
      ADCCT_CONV  = 2'b10
   } adcct_cst_t;

   typedef enum logic [1:0] {
      ADCCT_IDLE = 2'b00,
      ADCCT_ADDR = 2'b01,
      ADCCT_ACK  = 2'b11,
      ADCCT_REST = 2'b10
   } adcct_ist_t;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic rise(input logic prev, input logic cur);
      return ~prev & cur;
   endfunction

   function automatic logic fall(input logic prev, input logic cur);
      return prev & ~cur;
   endfunction

   function automatic logic [6:0] slave_addr(input adcct_as_t s, input logic variant);
      if (s.up_read != s.down_read) begin
         return ADDR_FLOAT;
      end
      if (!variant) begin
         return s.up_read ? ADDR_V0_VDD : ADDR_V0_GND;
      end
      return s.up_read ? ADDR_V1_VDD : ADDR_V1_GND;
   endfunction

endpackage

// ### adcct_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module adcct_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         resetn,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } adcct_sy_t;

   adcct_sy_t st;
   adcct_sy_t next_st;

   always_comb begin
      next_st = st;
      if (clk_en) begin
         next_st.s1 = d;
         next_st.s2 = st.s1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule
`default_nettype wire

// ### adcct_top.sv
// pin-level converter control: convert start, mode, flag pin, address select
`timescale 1ns/10ps
`default_nettype none
module adcct_top (
   input  wire logic                 core_clk,
   input  wire logic                 resetn,
   input  wire logic                 clk_en,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   input  wire logic                 convert_start_pin,
   input  wire adcct_pkg::adcct_as_t address_select_pin,
   input  wire logic                 variant_sel,
   input  wire logic [11:0]          first_analog_input,
   input  wire logic [11:0]          second_input_or_reference_pin,
   input  wire logic                 scl_i,
   input  wire logic                 sda_i,
   output logic                      sda_o,
   output logic                      sda_oe,
   output logic                      flag_o,
   output logic                      flag_oe,
   output adcct_pkg::adcct_ana_t     analog_ctl,
   output logic                      addr_hit
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      adcct_pkg::adcct_cst_t      cst;
      logic [adcct_pkg::CNT_W-1:0] cnt;
      logic                       start_d;
      logic                       short_pulse;
      logic                       chan;
      logic [11:0]                sample;
      logic [11:0]                result;
      logic                       res_chan;
      logic                       res_bad;
      logic                       alert;
      logic [6:0]                 cfg;
      logic [11:0]                upper;
      logic [11:0]                lower;
      logic                       strap_done;
      logic [1:0]                 strap_wait;
      logic [6:0]                 addr;
      logic [31:0]                rdata;
   } adcct_st_t;

   adcct_st_t st;
   adcct_st_t next_st;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic        start_s;
   logic [1:0]  as_s;
   logic        var_s;
   logic [11:0] in1_s;
   logic [11:0] in2_s;
   logic        scl_s;
   logic        sda_s;

   adcct_sync #(.W(1)) u_sync_start (
      .core_clk (core_clk),
      .resetn   (resetn),
      .clk_en   (clk_en),
      .d        (convert_start_pin),
      .q        (start_s)
   );

   adcct_sync #(.W(3)) u_sync_strap (
      .core_clk (core_clk),
      .resetn   (resetn),
      .clk_en   (clk_en),
      .d        ({address_select_pin, variant_sel}),
      .q        ({as_s, var_s})
   );

   adcct_sync #(.W(24)) u_sync_ana (
      .core_clk (core_clk),
      .resetn   (resetn),
      .clk_en   (clk_en),
      .d        ({first_analog_input, second_input_or_reference_pin}),
      .q        ({in1_s, in2_s})
   );

   adcct_sync #(.W(2)) u_sync_bus (
      .core_clk (core_clk),
      .resetn   (resetn),
      .clk_en   (clk_en),
      .d        ({scl_i, sda_i}),
      .q        ({scl_s, sda_s})
   );

   // ****************************************
   // serial address phase
   // ****************************************
   logic ack_oe;

   adcct_addr_match u_match (
      .core_clk (core_clk),
      .resetn   (resetn),
      .clk_en   (clk_en),
      .scl      (scl_s),
      .sda      (sda_s),
      .my_addr  (st.addr),
      .sda_oe   (ack_oe),
      .matched  (addr_hit)
   );

   // ****************************************
   // helpers
   // ****************************************
   // write strobe aimed at one offset
   function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] o);
      return w && a == o;
   endfunction

   // shared pin used as input only in dual mode
   function automatic logic pick_second(input logic [6:0] c);
      return !c[adcct_pkg::CFG_MODE_POS] && c[adcct_pkg::CFG_CHSEL_POS];
   endfunction

   // ****************************************
   // decoded configuration
   // ****************************************
   logic single_mode;
   logic busy_sel;
   logic alert_en;
   logic start_rise;
   logic start_fall;
   logic conv_done;
   logic pwr_done;
   logic out_of_range;
   logic hit_cfg;
   logic hit_upper;
   logic hit_lower;
   logic hit_status;
   logic converting;

   assign single_mode  = st.cfg[adcct_pkg::CFG_MODE_POS];
   assign busy_sel     = st.cfg[adcct_pkg::CFG_BUSY_POS];
   assign alert_en     = st.cfg[adcct_pkg::CFG_ALEN_POS];
   assign start_rise   = adcct_pkg::rise(st.start_d, start_s);
   assign start_fall   = adcct_pkg::fall(st.start_d, start_s);
   assign pwr_done     = st.cnt == adcct_pkg::CNT_W'(adcct_pkg::PWRUP_CYC - 1);
   assign conv_done    = st.cnt == adcct_pkg::CNT_W'(adcct_pkg::CONV_CYC - 1);
   assign out_of_range = (st.sample > st.upper) || (st.sample < st.lower);
   assign converting   = st.cst == adcct_pkg::ADCCT_CONV;

   // ****************************************
   // register write decode
   // ****************************************
   assign hit_cfg      = wr_hit(reg_wr, reg_addr, adcct_pkg::CFG_OFS);
   assign hit_upper    = wr_hit(reg_wr, reg_addr, adcct_pkg::UPPER_OFS);
   assign hit_lower    = wr_hit(reg_wr, reg_addr, adcct_pkg::LOWER_OFS);
   assign hit_status   = wr_hit(reg_wr, reg_addr, adcct_pkg::STATUS_OFS);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_st = st;
      if (clk_en) begin
         next_st.start_d = start_s;

         // strap caught once both synchroniser stages have filled
         if (!st.strap_done) begin
            if (st.strap_wait == 2'(adcct_pkg::SYNC_CYC)) begin
               next_st.strap_done = 1'b1;
               next_st.addr       = adcct_pkg::slave_addr(as_s, var_s);
            end else begin
               next_st.strap_wait = st.strap_wait + 2'h1;
            end
         end

         // conversion sequence
         case (st.cst)
            adcct_pkg::ADCCT_SLEEP: begin
               if (start_rise) begin
                  next_st.cst = adcct_pkg::ADCCT_PWRUP;
                  next_st.cnt = '0;
               end
            end
            adcct_pkg::ADCCT_PWRUP: begin
               if (start_fall) begin
                  next_st.cst         = adcct_pkg::ADCCT_CONV;
                  next_st.cnt         = '0;
                  // a pulse of the full power-up time is valid
                  next_st.short_pulse = !pwr_done;
                  next_st.chan        = pick_second(st.cfg);
               end else if (pwr_done) begin
                  next_st.cst = adcct_pkg::ADCCT_READY;
               end else begin
                  next_st.cnt = st.cnt + 1'b1;
               end
            end
            adcct_pkg::ADCCT_READY: begin
               if (start_fall) begin
                  next_st.cst         = adcct_pkg::ADCCT_CONV;
                  next_st.cnt         = '0;
                  // pulse met its minimum
                  next_st.short_pulse = 1'b0;
                  next_st.chan        = pick_second(st.cfg);
               end
            end
            adcct_pkg::ADCCT_CONV: begin
               if (conv_done) begin
                  // result, channel and validity latched together
                  next_st.cst      = adcct_pkg::ADCCT_SLEEP;
                  next_st.cnt      = '0;
                  next_st.result   = st.sample;
                  next_st.res_chan = st.chan;
                  next_st.res_bad  = st.short_pulse;
               end else begin
                  next_st.cnt = st.cnt + 1'b1;
               end
            end
            default: begin
               next_st.cst = adcct_pkg::ADCCT_SLEEP;
            end
         endcase

         // sample held from the falling edge onward
         if (!converting) begin
            next_st.sample = pick_second(st.cfg) ? in2_s : in1_s;
         end

         // registers, reachable in any power state
         if (hit_cfg) begin
            next_st.cfg = reg_wdata[6:0];
         end
         if (hit_upper) begin
            next_st.upper = reg_wdata[11:0];
         end
         if (hit_lower) begin
            next_st.lower = reg_wdata[11:0];
         end

         // sticky alert, set beats clear
         if (hit_status && reg_wdata[adcct_pkg::ST_ALERT_POS]) begin
            next_st.alert = 1'b0;
         end
         if (st.cst == adcct_pkg::ADCCT_CONV && conv_done && alert_en && out_of_range) begin
            next_st.alert = 1'b1;
         end

         // read data, valid the cycle after the strobe
         next_st.rdata = '0;
         if (reg_rd) begin
            case (reg_addr)
               adcct_pkg::CFG_OFS: begin
                  next_st.rdata[6:0] = st.cfg;
               end
               adcct_pkg::UPPER_OFS: begin
                  next_st.rdata[11:0] = st.upper;
               end
               adcct_pkg::LOWER_OFS: begin
                  next_st.rdata[11:0] = st.lower;
               end
               adcct_pkg::RESULT_OFS: begin
                  next_st.rdata[11:0]                   = st.result;
                  next_st.rdata[adcct_pkg::RES_CH_POS]  = st.res_chan;
                  next_st.rdata[adcct_pkg::RES_BAD_POS] = st.res_bad;
               end
               adcct_pkg::STATUS_OFS: begin
                  next_st.rdata[adcct_pkg::ST_ALERT_POS] = st.alert;
                  next_st.rdata[adcct_pkg::ST_BUSY_POS]  = st.cst == adcct_pkg::ADCCT_CONV;
                  next_st.rdata[adcct_pkg::ST_STATE_POS +: 2] = st.cst;
                  next_st.rdata[adcct_pkg::ST_ADDR_POS +: 7]  = st.addr;
               end
               default: begin
                  next_st.rdata = '0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st       <= '0;
         st.cfg   <= adcct_pkg::CFG_RST;
         st.upper <= adcct_pkg::UPPER_RST;
         st.lower <= adcct_pkg::LOWER_RST;
         st.addr  <= adcct_pkg::ADDR_FLOAT;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic flag_active;

   always_comb begin
      if (busy_sel) begin
         flag_active = converting;
      end else begin
         flag_active = st.alert && alert_en;
      end
   end

   assign reg_rdata = st.rdata;
   assign sda_o     = 1'b0;
   assign sda_oe    = ack_oe;
   assign flag_o    = 1'b0;
   assign flag_oe   = flag_active;

   always_comb begin
      analog_ctl                = '0;
      analog_ctl.ref_from_pin   = single_mode;
      analog_ctl.second_channel = st.chan && !single_mode;
      analog_ctl.powered        = st.cst != adcct_pkg::ADCCT_SLEEP;
      analog_ctl.hold           = converting;
   end

endmodule
`default_nettype wire

// ### adcct_top_assertions.sv
// port checker of the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcct_top_assertions (
   input wire logic                  core_clk,
   input wire logic                  resetn,
   input wire logic [7:0]            reg_addr,
   input wire logic [31:0]           reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [31:0]           reg_rdata,
   input wire logic                  convert_start_pin,
   input wire logic                  scl_i,
   input wire logic                  sda_o,
   input wire logic                  sda_oe,
   input wire logic                  flag_o,
   input wire logic                  flag_oe,
   input wire adcct_pkg::adcct_ana_t analog_ctl,
   input wire logic                  addr_hit
);
   // ******
   // config mirror
   // ******
   logic [6:0] cfg;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cfg <= adcct_pkg::CFG_RST;
      end else if (reg_wr && reg_addr == adcct_pkg::CFG_OFS) begin
         cfg <= reg_wdata[6:0];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_conv;
      analog_ctl.hold [*8] ##[30:34] !analog_ctl.hold;
   endsequence
   sequence s_idle;
      (!analog_ctl.powered && $stable(convert_start_pin)) [*6];
   endsequence
   // ******
   // properties
   // ******
   a_open_drain: assert property (sda_o == 1'b0 && flag_o == 1'b0)
      else $error("driven high level on open drain pin");
   a_pwr_rise: assert property ($rose(convert_start_pin) && !analog_ctl.powered
      |-> ##[2:5] analog_ctl.powered) else $error("no power up after start rise");
   a_hold_fall: assert property ($fell(convert_start_pin) && analog_ctl.powered
      && !analog_ctl.hold |-> ##[2:5] analog_ctl.hold) else $error("no hold after fall");
   a_conv_len: assert property ($rose(analog_ctl.hold) |-> s_conv)
      else $error("conversion length wrong");
   a_sleep_after: assert property ($fell(analog_ctl.hold) |-> !analog_ctl.powered)
      else $error("not asleep after conversion");
   a_edge_only: assert property (s_idle |=> !analog_ctl.powered)
      else $error("woke without an edge");
   a_busy_flag: assert property (cfg[5] |-> flag_oe == analog_ctl.hold)
      else $error("busy flag differs from conversion");
   a_alert_off: assert property (!cfg[5] && !cfg[4] |-> !flag_oe)
      else $error("alert active while disabled");
   a_ref_mode: assert property (analog_ctl.ref_from_pin == cfg[6]
      && (!cfg[6] || !analog_ctl.second_channel)) else $error("channel mode wrong");
   a_ack_hit: assert property ($rose(sda_oe) |-> addr_hit && !scl_i ##1 sda_oe)
      else $error("acknowledge without match");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
endmodule
bind adcct_top adcct_top_assertions chk_u (.core_clk(core_clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .convert_start_pin(convert_start_pin), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .flag_o(flag_o), .flag_oe(flag_oe),
   .analog_ctl(analog_ctl), .addr_hit(addr_hit));
`default_nettype wire

// ### tb_adcct_top.sv
// self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_adcct_top;
   logic                  core_clk, resetn, reg_wr, reg_rd, cs, var_sel, rd_seen;
   logic                  sda_oe, flag_o, flag_oe, sda_o, addr_hit, scl, ack;
   wire logic             sda;
   logic [7:0]            reg_addr;
   logic [31:0]           reg_wdata, reg_rdata, x;
   logic [11:0]           ain1, ain2, a1, a2;
   adcct_pkg::adcct_as_t  as_pin;
   adcct_pkg::adcct_ana_t ana;
   logic [31:0]           expq[$];
   logic [6:0]            exp_a [6] = '{7'h21, 7'h23, 7'h22, 7'h24, 7'h20, 7'h20};
   int                    err_total, num_checks, cyc, hits;
   adcct_top dut_u (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .convert_start_pin(cs), .address_select_pin(as_pin),
      .variant_sel(var_sel), .first_analog_input(ain1),
      .second_input_or_reference_pin(ain2), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .flag_o(flag_o), .flag_oe(flag_oe), .analog_ctl(ana),
      .addr_hit(addr_hit));
   adcct_i2c_host host_u (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   // ******
   // clock, watcher, timeout
   // ******
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      rd_seen <= reg_rd;
      cyc++;
      if (addr_hit === 1'b1) hits++;
      if (cyc == 6000) begin
         err_total++;
         results();
      end
   end
   always @(negedge core_clk) begin
      if (rd_seen === 1'b1) begin
         x = expq.pop_front();
         `CHK("rdata", x, reg_rdata)
      end
   end
   // ******
   // tasks
   // ******
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic phase(input logic [6:0] a, input logic e);
      host_u.addr_phase({a, 1'($urandom % 2)}, ack);
      `CHK("ack", e, ack)
      @(posedge core_clk);
   endtask
   task automatic conv(input int hi, input logic fl, input logic [31:0] res);
      int n;
      n = 0;
      cs <= 1'b1;
      repeat (hi) @(posedge core_clk);
      @(negedge core_clk);
      `CHK("powered", 1'b1, ana.powered)
      @(posedge core_clk);
      cs <= 1'b0;
      do @(negedge core_clk); while (ana.hold !== 1'b1 && ++n < 10);
      `CHK("hold", 1'b1, ana.hold)
      `CHK("flag", fl, flag_oe)
      do @(negedge core_clk); while (ana.powered !== 1'b0 && ++n < 80);
      `CHK("asleep", 1'b0, ana.powered)
      @(posedge core_clk);
      rd(adcct_pkg::RESULT_OFS, res);
   endtask
   // ******
   // tests
   // ******
   initial begin
      {resetn, reg_wr, reg_rd, cs, var_sel} = '0;
      {reg_addr, reg_wdata, ain1, ain2} = '0;
      as_pin = '0;
      {err_total, num_checks, cyc, hits} = '0;
      void'($urandom(50));
      for (int k = 0; k < 6; k++) begin
         resetn <= 1'b0;
         var_sel <= k[0];
         as_pin <= (k < 2) ? 2'b00 : (k < 4) ? 2'b11 : 2'b01;
         repeat (5) @(posedge core_clk);
         resetn <= 1'b1;
         repeat (3) @(posedge core_clk);
         if (k == 0) begin
            rd(adcct_pkg::CFG_OFS, 32'h0);
            rd(adcct_pkg::UPPER_OFS, 32'hFFF);
            rd(adcct_pkg::LOWER_OFS, 32'h0);
            rd(8'h14, 32'h0);
         end
         rd(adcct_pkg::STATUS_OFS, {21'h0, exp_a[k], 4'h0});
         hits = 0;
         phase(exp_a[k], 1'b0);
         phase(exp_a[k] + 7'h01, 1'b1);
         `CHK("hits", 1'b1, hits == 1)
      end
      $display("test address done");
      a1 = 12'($urandom);
      ain1 <= a1;
      ain2 <= 12'($urandom);
      wr(adcct_pkg::CFG_OFS, 32'h60);
      `CHK("single", 2'b10, {ana.ref_from_pin, ana.second_channel})
      conv(30, 1'b1, {20'h0, a1});
      `CHK("idle flag", 1'b0, flag_oe)
      $display("test busy done");
      a2 = 12'($urandom % 4000 + 50);
      ain2 <= a2;
      wr(adcct_pkg::UPPER_OFS, {20'h0, a2 - 12'h001});
      wr(adcct_pkg::CFG_OFS, 32'h11);
      `CHK("dual", 1'b0, ana.ref_from_pin)
      conv(30, 1'b0, {19'h0, 1'b1, a2});
      `CHK("dual ch", 2'b01, {ana.ref_from_pin, ana.second_channel})
      `CHK("alert", 1'b1, flag_oe)
      rd(adcct_pkg::STATUS_OFS, 32'h201);
      wr(adcct_pkg::STATUS_OFS, 32'h1);
      wr(adcct_pkg::CFG_OFS, 32'h01);
      wr(adcct_pkg::LOWER_OFS, {20'h0, a2 + 12'h001});
      conv(5, 1'b0, {16'h0, 4'h9, a2});
      `CHK("masked", 1'b0, flag_oe)
      $display("test alert done");
      results();
   end
endmodule
`default_nettype wire
